/* tws_terminal_watchdog.sv */
// tws_terminal_watchdog: terminal supervision - enable latch, awake input, watchdog, reset pulse
// assumes awake line is asynchronous; frame tick, code change and clock-resume are core-clock pulses
//
// Operation
// - enable bit gates all supervision behaviour
// - awake input honoured only while enabled
// - enable also unmasks awake and overflow flags
// - awake falling edge sets awake flag
// - correct pair restarts watchdog; expiry sets overflow
// - enable bit cleared only by hardware reset
// - select 0: pulse on awake, code change, resume
// - awake falling edge forces upstream data to zero
// - awake and code-change wake resets also set their interrupt flags; resume sets none
// - select 1: pulse only on watchdog expiry
// - watchdog halts while powered down, clocks stopped
// - select bit matters only when enabled
// - any select change clears watchdog timer
// - pulse active high 5ms, no internal reset
// - reset pin driven only during the pulse
`timescale 1ns/1ps
module tws_terminal_watchdog #(
  parameter int unsigned WDOG_TICKS  = tws_pkg::WDOG_TICKS,
  parameter int unsigned PULSE_TICKS = tws_pkg::PULSE_TICKS
) (
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     enable_set,
  input  wire logic                     reset_cause_select,
  input  wire logic                     trigger_wr,
  input  wire tws_pkg::tws_trigger_type trigger_data,
  input  wire logic                     external_awake_n,
  input  wire logic                     frame_tick,
  input  wire logic                     powered_down,
  input  wire logic                     command_change,
  input  wire logic                     clocks_resumed,
  input  wire logic                     upstream_data_in,
  input  wire tws_pkg::tws_flags_type   flag_clear,
  output logic                          terminal_functions_enable,
  output tws_pkg::tws_flags_type        d_ext_irq_status,
  output logic                          command_change_flag,
  output logic                          wake_pulse_out,
  output logic                          wake_pulse_oe,
  output logic                          upstream_data_line
);

  // ==========================================================================
  // parameter checks
  initial begin
    if (WDOG_TICKS < 2 || WDOG_TICKS >= (1 << tws_pkg::CNT_W)) begin
      $error("watchdog tick count out of range");
    end
    if (PULSE_TICKS < 1 || PULSE_TICKS >= (1 << tws_pkg::CNT_W)) begin
      $error("pulse tick count out of range");
    end
  end

  localparam logic [tws_pkg::CNT_W-1:0] WDOG_LAST  = tws_pkg::CNT_W'(WDOG_TICKS - 1);
  localparam logic [tws_pkg::CNT_W-1:0] PULSE_LAST = tws_pkg::CNT_W'(PULSE_TICKS - 1);
  localparam logic [tws_pkg::CNT_W-1:0] CNT_ZERO   = '0;

  // ==========================================================================
  // counter helpers shared by the watchdog and the pulse timer
  function automatic logic cnt_at(
    input logic [tws_pkg::CNT_W-1:0] value,
    input logic [tws_pkg::CNT_W-1:0] last
  );
    cnt_at = (value == last);
  endfunction : cnt_at

  function automatic logic [tws_pkg::CNT_W-1:0] cnt_next(
    input logic [tws_pkg::CNT_W-1:0] value
  );
    cnt_next = value + tws_pkg::CNT_W'(1);
  endfunction : cnt_next

  // ==========================================================================
  // enable latch
  logic tsf_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tsf_q <= tws_pkg::TSF_RESET;
    end else if (enable_set) begin
      tsf_q <= 1'b1;
    end
  end

  // ==========================================================================
  // awake line synchroniser and edge
  logic awake_s1_q;
  logic awake_s2_q;
  logic awake_s3_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      awake_s1_q <= 1'b1;
      awake_s2_q <= 1'b1;
      awake_s3_q <= 1'b1;
    end else begin
      awake_s1_q <= external_awake_n;
      awake_s2_q <= awake_s1_q;
      awake_s3_q <= awake_s2_q;
    end
  end

  wire awake_fall = tsf_q & awake_s3_q & ~awake_s2_q;
  wire rss_sel    = reset_cause_select;
  wire wake_src   = awake_fall | (tsf_q & (command_change | clocks_resumed));

  // ==========================================================================
  // trigger sequence: first write hi=1,lo=0 arms, then hi=0,lo=1 completes
  tws_pkg::tws_trig_state_type trig_q;
  tws_pkg::tws_trig_state_type trig_d;
  wire trig_first  = trigger_wr & trigger_data.hi & ~trigger_data.lo;
  wire trig_second = trigger_wr & ~trigger_data.hi & trigger_data.lo;

  always_comb begin
    trig_d = trig_q;
    case (trig_q)
      tws_pkg::TWS_TRIG_IDLE: begin
        if (trig_first) begin
          trig_d = tws_pkg::TWS_TRIG_ARMED;
        end
      end
      tws_pkg::TWS_TRIG_ARMED: begin
        if (trig_second) begin
          trig_d = tws_pkg::TWS_TRIG_DONE;
        end else if (trigger_wr && !trig_first) begin
          trig_d = tws_pkg::TWS_TRIG_IDLE;
        end
      end
      tws_pkg::TWS_TRIG_DONE: begin
        trig_d = trig_first ? tws_pkg::TWS_TRIG_ARMED : tws_pkg::TWS_TRIG_IDLE;
      end
      default: begin
        trig_d = tws_pkg::TWS_TRIG_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      trig_q <= tws_pkg::TWS_TRIG_IDLE;
    end else begin
      trig_q <= trig_d;
    end
  end

  wire serviced = (trig_q == tws_pkg::TWS_TRIG_DONE);

  // ==========================================================================
  // watchdog timer
  logic                     rss_q;
  logic [tws_pkg::CNT_W-1:0] wdog_q;
  wire rss_changed = rss_q ^ rss_sel;
  // halted while powered down so a stopped serial bus cannot spuriously expire
  wire wdog_tick   = tsf_q & frame_tick & ~powered_down;
  wire wdog_expire = wdog_tick & cnt_at(wdog_q, WDOG_LAST);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rss_q  <= tws_pkg::RSS_RESET;
      wdog_q <= CNT_ZERO;
    end else begin
      rss_q <= rss_sel;
      if (!tsf_q || serviced || rss_changed || wdog_expire) begin
        wdog_q <= CNT_ZERO;
      end else if (wdog_tick) begin
        wdog_q <= cnt_next(wdog_q);
      end
    end
  end

  // ==========================================================================
  // interrupt status flags: set wins over clear
  // the code-change flag has no clear bit of its own; both clear bits together
  // retire it one cycle late, so a change arriving in that cycle still wins
  logic saw_q;
  logic wov_q;
  logic cic_q;
  logic command_change_ack_q;
  wire  saw_d = awake_fall | (saw_q & ~flag_clear.subscriber_awake);
  wire  wov_d = wdog_expire | (wov_q & ~flag_clear.watchdog_overflow);
  wire  cic_d = (tsf_q & command_change) | (cic_q & ~command_change_ack_q);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      saw_q <= 1'b0;
    end else begin
      saw_q <= saw_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wov_q <= 1'b0;
    end else begin
      wov_q <= wov_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cic_q <= 1'b0;
    end else begin
      cic_q <= cic_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      command_change_ack_q <= 1'b0;
    end else begin
      command_change_ack_q <= flag_clear.subscriber_awake & flag_clear.watchdog_overflow;
    end
  end

  // ==========================================================================
  // reset pulse generator
  wire pulse_start = tsf_q & (rss_sel ? wdog_expire : wake_src);
  logic                     pulse_q;
  logic [tws_pkg::CNT_W-1:0] pulse_cnt_q;
  wire pulse_tick = frame_tick & ~powered_down;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pulse_q     <= 1'b0;
      pulse_cnt_q <= CNT_ZERO;
    end else if (!pulse_q && pulse_start) begin
      pulse_q     <= 1'b1;
      pulse_cnt_q <= CNT_ZERO;
    end else if (pulse_q && pulse_tick) begin
      if (cnt_at(pulse_cnt_q, PULSE_LAST)) begin
        pulse_q <= 1'b0;
      end else begin
        pulse_cnt_q <= cnt_next(pulse_cnt_q);
      end
    end
  end

  // ==========================================================================
  // upstream data forcing: held low from the awake edge until clocks resume
  logic du_force_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      du_force_q <= 1'b0;
    end else if (awake_fall) begin
      du_force_q <= 1'b1;
    end else if (clocks_resumed) begin
      du_force_q <= 1'b0;
    end
  end

  // ==========================================================================
  // registered outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      terminal_functions_enable <= 1'b0;
    end else begin
      terminal_functions_enable <= tsf_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      d_ext_irq_status <= '0;
    end else begin
      d_ext_irq_status <= '{subscriber_awake: saw_q, watchdog_overflow: wov_q};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      command_change_flag <= 1'b0;
    end else begin
      command_change_flag <= cic_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wake_pulse_out <= 1'b0;
    end else begin
      wake_pulse_out <= pulse_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wake_pulse_oe <= 1'b0;
    end else begin
      wake_pulse_oe <= pulse_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      upstream_data_line <= 1'b1;
    end else begin
      upstream_data_line <= upstream_data_in & ~(du_force_q | awake_fall);
    end
  end

endmodule : tws_terminal_watchdog

/* tws_pkg.sv */
// tws_pkg: shared constants and carrier types for the terminal supervision block
// assumes a 20 MHz core clock and a frame-rate enable from the system-side serial interface
package tws_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CORE_CLK_HZ      = 20000000;
  localparam int unsigned FRAME_HZ         = 8000;
  localparam int unsigned WDOG_INTERVAL_MS = 128;
  localparam int unsigned PULSE_WIDTH_MS   = 5;
  // counts are in frame-rate ticks; the interval is a longest time, the pulse a least time
  localparam int unsigned WDOG_TICKS  = (WDOG_INTERVAL_MS * FRAME_HZ) / 1000;
  localparam int unsigned PULSE_TICKS = (PULSE_WIDTH_MS * FRAME_HZ + 999) / 1000;
  localparam int unsigned CNT_W       = 16;

  // ==========================================================================
  // reset values
  localparam logic TSF_RESET = 1'b0;
  localparam logic RSS_RESET = 1'b0;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic hi;
    logic lo;
  } tws_trigger_type;

  typedef struct packed {
    logic subscriber_awake;
    logic watchdog_overflow;
  } tws_flags_type;

  typedef enum logic [2:0] {
    TWS_TRIG_IDLE  = 3'b001,
    TWS_TRIG_ARMED = 3'b010,
    TWS_TRIG_DONE  = 3'b100
  } tws_trig_state_type;

endpackage : tws_pkg

/* tws_partner.sv */
// tws_partner: awake key and the host reset input at the far side
// assumes the bench presses the key; the awake line pulls up, the reset input pulls down
`timescale 1ns/1ps
module tws_partner (
  input  wire logic key_press,
  input  wire logic wake_pulse_out,
  input  wire logic wake_pulse_oe,
  output logic      external_awake_n,
  output logic      reset_seen
);
  assign external_awake_n = !key_press;
  // released pin falls to the pull-down, never the last driven value
  assign reset_seen = wake_pulse_oe ? wake_pulse_out : 1'b0;
endmodule : tws_partner

/* tws_terminal_watchdog_asserts.sv */
// tws_terminal_watchdog_asserts: port checks for the supervision block
// assumes one core_clk domain with synchronous active-high sys_rst
`timescale 1ns/1ps
module tws_terminal_watchdog_asserts #(
  parameter int unsigned PULSE_TICKS = 3
) (
  input wire logic                   core_clk,
  input wire logic                   sys_rst,
  input wire logic                   reset_cause_select,
  input wire logic                   external_awake_n,
  input wire logic                   frame_tick,
  input wire logic                   command_change,
  input wire tws_pkg::tws_flags_type flag_clear,
  input wire logic                   terminal_functions_enable,
  input wire tws_pkg::tws_flags_type d_ext_irq_status,
  input wire logic                   command_change_flag,
  input wire logic                   wake_pulse_out,
  input wire logic                   wake_pulse_oe,
  input wire logic                   upstream_data_line
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // frame ticks seen while the pulse stands
  logic [7:0] ticks_q;
  logic [7:0] ticks_d;
  assign ticks_d = wake_pulse_out ? ticks_q + {7'h00, frame_tick} : 8'h00;
  always_ff @(posedge core_clk) ticks_q <= sys_rst ? 8'h00 : ticks_d;
  a_pin_drive_only: assert property (wake_pulse_oe == wake_pulse_out)
    else $error("reset pin enable differs from pulse");
  a_enable_sticky: assert property (terminal_functions_enable |=> terminal_functions_enable)
    else $error("enable dropped without reset");
  a_dormant_quiet: assert property (!terminal_functions_enable |->
    !wake_pulse_oe && d_ext_irq_status == 2'b00 && !command_change_flag) else $error("activity while disabled");
  a_code_change_pulse: assert property (terminal_functions_enable && !reset_cause_select
    && $stable(reset_cause_select) && command_change && !wake_pulse_out
    |-> ##[1:3] (command_change_flag && wake_pulse_out)) else $error("code change gave no pulse");
  a_select_expiry_only: assert property ($rose(wake_pulse_out) && reset_cause_select
    && $past(reset_cause_select, 3) |-> d_ext_irq_status.watchdog_overflow) else $error("pulse without expiry");
  a_awake_edge_effect: assert property ($fell(external_awake_n) && terminal_functions_enable
    && !reset_cause_select |-> ##[2:6] (!upstream_data_line && d_ext_irq_status.subscriber_awake))
    else $error("awake edge not seen");
  a_overflow_holds: assert property (d_ext_irq_status.watchdog_overflow && !flag_clear.watchdog_overflow
    && !$past(flag_clear.watchdog_overflow) |=> d_ext_irq_status.watchdog_overflow) else $error("overflow lost");
  a_pulse_width_ticks: assert property ($fell(wake_pulse_out)
    |-> ticks_q >= PULSE_TICKS && ticks_q <= PULSE_TICKS + 1) else $error("pulse width wrong");
  c_pulse: cover property ($rose(wake_pulse_out));
  c_overflow: cover property ($rose(d_ext_irq_status.watchdog_overflow));
  c_awake: cover property ($rose(d_ext_irq_status.subscriber_awake));
endmodule : tws_terminal_watchdog_asserts
bind tws_terminal_watchdog tws_terminal_watchdog_asserts #(.PULSE_TICKS(PULSE_TICKS)) i_tws_terminal_watchdog_asserts (
  .core_clk, .sys_rst, .reset_cause_select, .external_awake_n, .frame_tick, .command_change, .flag_clear,
  .terminal_functions_enable, .d_ext_irq_status, .command_change_flag, .wake_pulse_out, .wake_pulse_oe,
  .upstream_data_line);

/* tws_terminal_watchdog_bench.sv */
// tws_terminal_watchdog_bench: directed scenarios for the supervision block
// assumes tws_pkg, the design, the far-side model and the checker are compiled first
`timescale 1ns/1ps
module tws_terminal_watchdog_bench;
  localparam int WD = 8;
  localparam int PT = 3;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic en_set = 1'b0, sel = 1'b0, twr = 1'b0, key = 1'b0, ftick = 1'b0, pdown = 1'b0, cchg = 1'b0, cres = 1'b0;
  tws_pkg::tws_trigger_type tdat = 2'b00;
  tws_pkg::tws_flags_type   fclr = 2'b00;
  tws_pkg::tws_flags_type   flags;
  logic tfe, ccf, wpo, wpoe, awake_n, rst_pin, udl;
  int n_errors = 0;
  int n_tests = 0;
  int k;
  always #25 core_clk = ~core_clk;
  tws_terminal_watchdog #(.WDOG_TICKS(WD), .PULSE_TICKS(PT)) i_tws_terminal_watchdog (.core_clk(core_clk),
    .sys_rst(sys_rst), .enable_set(en_set), .reset_cause_select(sel), .trigger_wr(twr), .trigger_data(tdat),
    .external_awake_n(awake_n), .frame_tick(ftick), .powered_down(pdown), .command_change(cchg),
    .clocks_resumed(cres), .upstream_data_in(1'b1), .flag_clear(fclr), .terminal_functions_enable(tfe),
    .d_ext_irq_status(flags), .command_change_flag(ccf), .wake_pulse_out(wpo), .wake_pulse_oe(wpoe),
    .upstream_data_line(udl));
  tws_partner i_tws_partner (.key_press(key), .wake_pulse_out(wpo), .wake_pulse_oe(wpoe),
    .external_awake_n(awake_n), .reset_seen(rst_pin));
  // ==========================================================================
  // drivers start on a rising edge; look settles on the falling edge
  task automatic cyc(input int n); repeat (n) @(posedge core_clk); endtask : cyc
  task automatic look(input int n); cyc(n); @(negedge core_clk); endtask : look
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) begin
      cyc(1); ftick <= 1'b1; cyc(1); ftick <= 1'b0; cyc(1);
    end
  endtask : tick
  task automatic trig(input logic hi, input logic lo);
    cyc(1); tdat <= '{hi: hi, lo: lo}; twr <= 1'b1; cyc(1); twr <= 1'b0;
  endtask : trig
  task automatic service; trig(1'b1, 1'b0); trig(1'b0, 1'b1); cyc(3); endtask : service
  task automatic strobe(input logic [2:0] s);
    cyc(1); {cchg, cres, en_set} <= s; cyc(1); {cchg, cres, en_set} <= 3'h0;
  endtask : strobe
  task automatic clr; cyc(1); fclr <= 2'b11; cyc(1); fclr <= 2'b00; cyc(3); endtask : clr
  // used: frame ticks the pulse has already counted before this call
  task automatic pulse_len(input int used);
    for (k = 0; k < 20; k++) begin
      @(negedge core_clk);
      if (rst_pin !== 1'b1) break;
      tick(1);
    end
    chk(8'(k == PT - used), 8'h01);
  endtask : pulse_len
  // ==========================================================================
  // scenarios
  task automatic t_dormant;
    cyc(1); sel <= 1'b1; key <= 1'b1; strobe(3'b110); tick(WD + 2); cyc(1); key <= 1'b0; look(3);
    chk({tfe, flags, ccf, rst_pin}, 8'h00);
    chk(udl, 8'h01);
    cyc(1); sel <= 1'b0; $display("dormant done");
  endtask : t_dormant
  task automatic t_wake;
    strobe(3'b001); look(2); chk(tfe, 8'h01);
    strobe(3'b100); look(3); chk({ccf, rst_pin}, 8'h03);
    pulse_len(0); clr(); key <= 1'b1; look(6);
    chk({flags.subscriber_awake, udl, rst_pin}, 8'h05);
    pulse_len(0); cyc(1); key <= 1'b0; strobe(3'b010); look(3);
    chk({udl, rst_pin}, 8'h03);
    pulse_len(0); clr(); $display("wake done");
  endtask : t_wake
  task automatic t_watchdog;
    cyc(1); sel <= 1'b1; clr();
    repeat (3) begin tick(WD - 2); service(); end
    look(1); chk(flags.watchdog_overflow, 8'h00);
    tick(WD - 1); look(3); chk(flags.watchdog_overflow, 8'h00);
    tick(2); look(3); chk({flags.watchdog_overflow, rst_pin}, 8'h03);
    pulse_len(1); clr(); strobe(3'b100); look(3); chk(rst_pin, 8'h00);
    service(); tick(WD - 2); cyc(1); sel <= 1'b0; cyc(1); sel <= 1'b1; tick(WD - 2); look(3);
    chk(flags.watchdog_overflow, 8'h00);
    service(); cyc(1); pdown <= 1'b1; tick(WD + 2); look(3);
    chk(flags.watchdog_overflow, 8'h00);
    cyc(1); pdown <= 1'b0; look(1); chk(tfe, 8'h01);
    $display("watchdog done");
  endtask : t_watchdog
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    cyc(3); sys_rst <= 1'b0;
    t_dormant(); t_wake(); t_watchdog(); conclude();
  end
endmodule : tws_terminal_watchdog_bench
